// File: aofc_pkg.sv
// Summary of operation
// - Five-bit cap2 code, linear, resets to 00111.
// - Synth output needs output, bias, core enables.
// - Format bit set gives offset binary output.
// - Mode 10 DDR LVDS, 01 CMOS, 00 off.
// - DDR sends even bits rising, odd falling.
// - Pattern 000 passes converter data.
// - Pattern 111 sends LFSR pseudo-random words.
// - Pattern 110 sends eight ones, four zeros.
// - Pattern 101 sends 0101 0101 1010.
// - Pattern 100 alternates all ones, all zeros.
// - Pattern 011 alternates 0101 and 1010 words.
// - Pattern 010 ramps once per 64 clocks.
// - Ramp steps overrange and word clock bits.
// - Pattern 001 alternates custom words A, B.
// - Custom bit 11 overrange, bit 10 word clock.
// - LVDS patterns drive only enabled pins.
// - CMOS patterns drive every output pin.
// - Termination bit enables internal load.
// - Drive current codes; reserved codes not written.
// - Phase enable gates the phase step field.
// - Phase step is code times 45 degrees; default filters add 45 to even codes.
// - Phase stepping needs decimation above two.
package aofc_pkg;
  localparam logic [7:0] ADDR_CAP2   = 8'h5d;
  localparam logic [7:0] ADDR_SYNTH  = 8'h5f;
  localparam logic [7:0] ADDR_FORMAT = 8'h62;
  localparam logic [7:0] ADDR_LVDS   = 8'h63;
  localparam logic [7:0] ADDR_PHASE  = 8'h64;
  localparam logic [7:0] ADDR_PATA   = 8'h74;
  localparam logic [7:0] ADDR_PATB   = 8'h76;
  // Reset values, factory bits included.
  localparam logic [7:0] RST_CAP2    = 8'h27;
  localparam logic [7:0] RST_SYNTH   = 8'hf1;
  localparam logic [7:0] RST_FORMAT  = 8'h10;
  localparam logic [7:0] RST_LVDS    = 8'h01;
  localparam logic [7:0] RST_PHASE   = 8'h03;
  localparam logic [11:0] RST_PAT    = 12'h000;
  localparam logic [7:0] MASK_CAP2   = 8'h7f;
  localparam logic [7:0] MASK_FORMAT = 8'h7f;
  localparam int SYNTH_OUT_BIT  = 3;
  localparam int SYNTH_BIAS_BIT = 2;
  localparam int FORMAT_BIT     = 5;
  localparam int LOAD_BIT       = 3;
  localparam int PHEN_BIT       = 7;
  localparam logic [5:0] RAMP_DIV = 6'h3f;
  localparam int OVERRANGE_SHIFT  = 19;
  localparam int WORD_CLOCK_SHIFT = 18;
  localparam logic [11:0] SYNC_WORD = 12'hff0;
  localparam logic [11:0] ALT_LVDS  = 12'h55a;
  localparam logic [11:0] ALT_CMOS  = 12'h555;
  localparam logic [11:0] LFSR_SEED = 12'hfff;
  typedef enum logic [1:0] {
    AOFC_OFF  = 2'b00,
    AOFC_CMOS = 2'b01,
    AOFC_DDR  = 2'b10,
    AOFC_UNDEF = 2'b11
  } aofc_mode_t;
  typedef enum logic [2:0] {
    PAT_NORMAL = 3'b000, PAT_CUSTOM = 3'b001, PAT_RAMP = 3'b010,
    PAT_ALTC = 3'b011, PAT_ONEZ = 3'b100, PAT_ALTL = 3'b101,
    PAT_SYNC = 3'b110, PAT_PN = 3'b111
  } aofc_pat_t;
  typedef struct packed {
    logic [11:0] data;
    logic        overrange;
    logic        wordClock;
  } aofc_word_t;
endpackage

// File: aofc_core.sv
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module aofc_core (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdata,
  input  wire logic        synthCoreEnable,
  input  wire logic [11:0] adcData,
  input  wire logic        adcOverrange,
  input  wire logic        outWordClock,
  input  wire logic        lanesEnabled,
  input  wire logic        markerPairEnabled,
  input  wire logic [7:0]  decimRatio,
  input  wire logic        defaultFilters,
  output logic      [4:0]  loopCap2Select,
  output logic             synthOutActive,
  output logic             lvdsLoadEnable,
  output logic      [2:0]  lvdsDriveCurrent,
  output logic      [8:0]  clockPhaseDeg,
  output logic      [11:0] cmosData,
  output logic      [5:0]  lvdsData,
  output logic             overrangeBit,
  output logic             wordClockBit,
  output logic      [3:0]  spareTestPins,
  output logic      [11:0] dataOen,
  output logic             overrangeOen,
  output logic             wordClockOen,
  output logic      [3:0]  spareOen
);
  logic [7:0] cap2Reg, synthReg, fmtReg, lvdsReg, phaseReg;
  logic [11:0] patA, patB;
  logic [1:0] clkSync;
  logic       clkSeen;
  logic       sampleRise, sampleFall;
  logic [11:0] lfsr, ramp;
  logic [19:0] rampCount;
  logic        altSel;
  aofc_pkg::aofc_word_t nextWord, outWord;
  aofc_pkg::aofc_mode_t mode;
  aofc_pkg::aofc_pat_t  pattern;

  assign mode    = aofc_pkg::aofc_mode_t'(fmtReg[4:3]);
  assign pattern = aofc_pkg::aofc_pat_t'(fmtReg[2:0]);

  // Register writes; pattern words sit in two registers each.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cap2Reg  <= aofc_pkg::RST_CAP2;
      synthReg <= aofc_pkg::RST_SYNTH;
      fmtReg   <= aofc_pkg::RST_FORMAT;
      lvdsReg  <= aofc_pkg::RST_LVDS;
      phaseReg <= aofc_pkg::RST_PHASE;
      patA     <= aofc_pkg::RST_PAT;
      patB     <= aofc_pkg::RST_PAT;
    end else if (regWr) begin
      if (regAddr == aofc_pkg::ADDR_CAP2) begin
        cap2Reg <= regWdata & aofc_pkg::MASK_CAP2;
      end else if (regAddr == aofc_pkg::ADDR_SYNTH) begin
        synthReg <= regWdata;
      end else if (regAddr == aofc_pkg::ADDR_FORMAT) begin
        fmtReg <= regWdata & aofc_pkg::MASK_FORMAT;
      end else if (regAddr == aofc_pkg::ADDR_LVDS) begin
        lvdsReg <= regWdata;
      end else if (regAddr == aofc_pkg::ADDR_PHASE) begin
        phaseReg <= regWdata;
      end else if (regAddr == aofc_pkg::ADDR_PATA) begin
        patA[3:0] <= regWdata[7:4];
      end else if (regAddr == (aofc_pkg::ADDR_PATA + 8'h01)) begin
        patA[11:4] <= regWdata;
      end else if (regAddr == aofc_pkg::ADDR_PATB) begin
        patB[3:0] <= regWdata[7:4];
      end else if (regAddr == (aofc_pkg::ADDR_PATB + 8'h01)) begin
        patB[11:4] <= regWdata;
      end
    end
  end

  // Read data stands one cycle after the strobe; unmapped reads zero.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      if (regAddr == aofc_pkg::ADDR_CAP2) begin
        regRdata <= cap2Reg;
      end else if (regAddr == aofc_pkg::ADDR_SYNTH) begin
        regRdata <= synthReg;
      end else if (regAddr == aofc_pkg::ADDR_FORMAT) begin
        regRdata <= fmtReg;
      end else if (regAddr == aofc_pkg::ADDR_LVDS) begin
        regRdata <= lvdsReg;
      end else if (regAddr == aofc_pkg::ADDR_PHASE) begin
        regRdata <= phaseReg;
      end else if (regAddr == aofc_pkg::ADDR_PATA) begin
        regRdata <= {patA[3:0], 4'h0};
      end else if (regAddr == (aofc_pkg::ADDR_PATA + 8'h01)) begin
        regRdata <= patA[11:4];
      end else if (regAddr == aofc_pkg::ADDR_PATB) begin
        regRdata <= {patB[3:0], 4'h0};
      end else if (regAddr == (aofc_pkg::ADDR_PATB + 8'h01)) begin
        regRdata <= patB[11:4];
      end else begin
        regRdata <= 8'h00;
      end
    end else begin
      regRdata <= 8'h00;
    end
  end

  // Analog controls are plain decodes of the stored fields; synth output also needs the core enable.
  assign loopCap2Select   = cap2Reg[4:0];
  assign synthOutActive   = synthReg[aofc_pkg::SYNTH_OUT_BIT]
                          & synthReg[aofc_pkg::SYNTH_BIAS_BIT]
                          & synthCoreEnable;
  assign lvdsLoadEnable   = lvdsReg[aofc_pkg::LOAD_BIT];
  assign lvdsDriveCurrent = lvdsReg[2:0];

  // With default filters only odd phase steps exist; even codes round up.
  always_comb begin
    clockPhaseDeg = 9'h000;
    if (phaseReg[aofc_pkg::PHEN_BIT] && decimRatio > 8'h02) begin
      clockPhaseDeg = 9'(phaseReg[6:4]) * 9'd45;
      if (defaultFilters && !phaseReg[4]) begin
        clockPhaseDeg = 9'(phaseReg[6:4]) * 9'd45 + 9'd45;
      end
    end
  end

  // The word clock arrives from outside, so it is synchronised first.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clkSync <= 2'b00;
      clkSeen <= 1'b0;
    end else begin
      clkSync <= {clkSync[0], outWordClock};
      clkSeen <= clkSync[1];
    end
  end
  assign sampleRise = clkSync[1] & ~clkSeen;
  assign sampleFall = ~clkSync[1] & clkSeen;

  // LFSR and A/B select advance once per sample; the ramp once per 64 clocks.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lfsr      <= aofc_pkg::LFSR_SEED;
      altSel    <= 1'b0;
      rampCount <= 20'h00000;
      ramp      <= 12'h000;
    end else begin
      rampCount <= rampCount + 20'h00001;
      if (rampCount[5:0] == aofc_pkg::RAMP_DIV) begin
        ramp <= ramp + 12'h001;
      end
      if (sampleRise) begin
        lfsr   <= {lfsr[10:0], lfsr[11] ^ lfsr[10] ^ lfsr[9] ^ lfsr[3]};
        altSel <= ~altSel;
      end
    end
  end

  // Source selection with the number format applied to live data.
  always_comb begin
    nextWord = '0;
    case (pattern)
      aofc_pkg::PAT_NORMAL: begin
        nextWord.data = fmtReg[aofc_pkg::FORMAT_BIT] ?
                        {~adcData[11], adcData[10:0]} : adcData;
        nextWord.overrange = adcOverrange;
        nextWord.wordClock = clkSync[1];
      end
      aofc_pkg::PAT_CUSTOM: begin
        nextWord.data      = altSel ? patB : patA;
        nextWord.overrange = nextWord.data[11];
        nextWord.wordClock = nextWord.data[10];
      end
      aofc_pkg::PAT_RAMP: begin
        nextWord.data      = ramp;
        nextWord.overrange = rampCount[aofc_pkg::OVERRANGE_SHIFT];
        nextWord.wordClock = rampCount[aofc_pkg::WORD_CLOCK_SHIFT];
      end
      aofc_pkg::PAT_ALTC: begin
        nextWord.data = altSel ? ~aofc_pkg::ALT_CMOS : aofc_pkg::ALT_CMOS;
      end
      aofc_pkg::PAT_ONEZ: begin
        nextWord.data = altSel ? 12'h000 : 12'hfff;
      end
      aofc_pkg::PAT_ALTL: nextWord.data = aofc_pkg::ALT_LVDS;
      aofc_pkg::PAT_SYNC: nextWord.data = aofc_pkg::SYNC_WORD;
      default: nextWord.data = lfsr;
    endcase
  end

  // Words are captured on the sample edge so both halves stay aligned.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      outWord <= '0;
    end else if (sampleRise) begin
      outWord <= nextWord;
    end
  end

  // DDR lanes carry even bits in the high phase and odd bits in the low.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lvdsData <= 6'h00;
    end else if (sampleRise) begin
      lvdsData <= {nextWord.data[10], nextWord.data[8], nextWord.data[6],
                   nextWord.data[4], nextWord.data[2], nextWord.data[0]};
    end else if (sampleFall) begin
      lvdsData <= {outWord.data[11], outWord.data[9], outWord.data[7],
                   outWord.data[5], outWord.data[3], outWord.data[1]};
    end
  end

  assign cmosData      = outWord.data;
  assign overrangeBit  = outWord.overrange;
  assign wordClockBit  = outWord.wordClock;
  assign spareTestPins = outWord.data[3:0];

  // Enables are active low; undefined mode is held quiet as a safe choice.
  always_comb begin
    dataOen      = 12'hfff;
    overrangeOen = 1'b1;
    wordClockOen = 1'b1;
    spareOen     = 4'hf;
    if (mode == aofc_pkg::AOFC_CMOS) begin
      dataOen      = 12'h000;
      overrangeOen = ~(markerPairEnabled
                       || pattern != aofc_pkg::PAT_NORMAL);
      wordClockOen = overrangeOen;
      if (pattern != aofc_pkg::PAT_NORMAL) begin
        spareOen = 4'h0;
      end
    end else if (mode == aofc_pkg::AOFC_DDR) begin
      dataOen      = lanesEnabled ? 12'hfc0 : 12'hfff;
      overrangeOen = ~markerPairEnabled;
      wordClockOen = ~markerPairEnabled;
    end
  end

  // A write that clears the output enable must switch the synth off.
  a_synth_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    regWr && regAddr == aofc_pkg::ADDR_SYNTH
    && !regWdata[aofc_pkg::SYNTH_OUT_BIT] |=> !synthOutActive)
    else $error("synth output active after disable write");
  a_read_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    regRd && regAddr == 8'h00 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  a_off_quiet: assert property (@(posedge ref_clk) disable iff (!rstn)
    mode == aofc_pkg::AOFC_OFF |-> (dataOen == 12'hfff && overrangeOen))
    else $error("outputs driven while off");
  a_cmos_drive: assert property (@(posedge ref_clk) disable iff (!rstn)
    mode == aofc_pkg::AOFC_CMOS && pattern != aofc_pkg::PAT_NORMAL
    |-> (spareOen == 4'h0 && !overrangeOen && !wordClockOen))
    else $error("cmos pattern pins idle");
  a_phase_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    !phaseReg[aofc_pkg::PHEN_BIT] |-> clockPhaseDeg == 9'h000)
    else $error("phase moved while disabled");
  a_sync_word: assert property (@(posedge ref_clk) disable iff (!rstn)
    sampleRise && pattern == aofc_pkg::PAT_SYNC
    |=> cmosData == aofc_pkg::SYNC_WORD)
    else $error("sync word wrong");
  a_ramp_step: assert property (@(posedge ref_clk) disable iff (!rstn)
    rampCount[5:0] != aofc_pkg::RAMP_DIV |=> $stable(ramp))
    else $error("ramp stepped early");
  a_custom_marks: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    sampleRise && pattern == aofc_pkg::PAT_CUSTOM
    |=> overrangeBit == cmosData[11] && wordClockBit == cmosData[10])
    else $error("custom pattern marker bits wrong");
endmodule // aofc_core
`default_nettype wire

// File: aofc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host receiver model. It samples in mid-word, away from the source update.
module aofc_host_model (
  input  wire logic        outWordClock,
  input  wire logic [11:0] cmosData,
  input  wire logic        overrangeBit,
  input  wire logic        wordClockBit,
  input  wire logic [5:0]  lvdsData,
  output var aofc_pkg::aofc_word_t capWord,
  output var logic  [11:0] lvdsWord,
  output var int           capCount
);
  logic [5:0] evenHalf;
  initial capCount = 0;
  // Parallel word and the even half of the DDR word, first half of a word.
  always @(negedge outWordClock) begin
    capWord  <= '{data: cmosData, overrange: overrangeBit,
                  wordClock: wordClockBit};
    evenHalf <= lvdsData;
    capCount <= capCount + 1;
  end
  // Odd half comes after the falling edge, so it is taken in the second half.
  always @(posedge outWordClock) begin
    for (int i = 0; i < 6; i++) begin
      lvdsWord[2*i]   <= evenHalf[i];
      lvdsWord[2*i+1] <= lvdsData[i];
    end
  end
endmodule // aofc_host_model
`default_nettype wire

// File: test_adc_output_format_config.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_output_format_config;
  logic ref_clk = 1'b0, rstn, regWr, regRd, synthCoreEnable, adcOverrange;
  logic outWordClock, lanesEnabled, markerPairEnabled, defaultFilters;
  logic [7:0] regAddr, regWdata, decimRatio, regRdata;
  logic [11:0] adcData, cmosData, dataOen, lvdsWord, r;
  logic [4:0] loopCap2Select;
  logic [2:0] lvdsDriveCurrent;
  logic [8:0] clockPhaseDeg;
  logic [5:0] lvdsData;
  logic [3:0] spareTestPins, spareOen;
  logic synthOutActive, lvdsLoadEnable, overrangeBit, wordClockBit;
  logic overrangeOen, wordClockOen;
  aofc_pkg::aofc_word_t capWord;
  int capCount, mismatches = 0, checkCount = 0;
  logic [7:0] regA [5] = '{8'h5d, 8'h5f, 8'h62, 8'h63, 8'h64};
  logic [7:0] regR [5] = '{8'h27, 8'hf1, 8'h10, 8'h01, 8'h03};
  logic [2:0] patS [5] = '{3'h4, 3'h3, 3'h6, 3'h5, 3'h1};
  logic [11:0] patA [5] = '{12'hfff, 12'h555, 12'hff0, 12'h55a, 12'h9c3};
  logic [11:0] patB [5] = '{12'h000, 12'haaa, 12'hff0, 12'h55a, 12'h36e};
  logic [2:0] curS [4] = '{3'h7, 3'h3, 3'h0, 3'h1};

  aofc_core i_dut (.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .synthCoreEnable(synthCoreEnable), .adcData(adcData),
    .adcOverrange(adcOverrange), .outWordClock(outWordClock),
    .lanesEnabled(lanesEnabled), .markerPairEnabled(markerPairEnabled),
    .decimRatio(decimRatio),
    .defaultFilters(defaultFilters), .loopCap2Select(loopCap2Select),
    .synthOutActive(synthOutActive), .lvdsLoadEnable(lvdsLoadEnable),
    .lvdsDriveCurrent(lvdsDriveCurrent), .clockPhaseDeg(clockPhaseDeg),
    .cmosData(cmosData), .lvdsData(lvdsData), .overrangeBit(overrangeBit),
    .wordClockBit(wordClockBit), .spareTestPins(spareTestPins),
    .dataOen(dataOen), .overrangeOen(overrangeOen),
    .wordClockOen(wordClockOen), .spareOen(spareOen));
  aofc_host_model i_host (.outWordClock(outWordClock), .cmosData(cmosData),
    .overrangeBit(overrangeBit), .wordClockBit(wordClockBit),
    .lvdsData(lvdsData), .capWord(capWord), .lvdsWord(lvdsWord),
    .capCount(capCount));

  // Core clock, 5 ns period.
  always #2.5 ref_clk = ~ref_clk;
  // Word clock, 125 ns period, offset so its edges never meet the core clock.
  initial begin
    outWordClock = 1'b0;
    #1.3;
    forever #62.5 outWordClock = ~outWordClock;
  end

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so look there.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    chk({8'h00, regRdata}, {8'h00, exp});
  endtask

  // Waits for n captured words; the guard stops a dead word clock hanging us.
  task automatic words(input int n);
    int start;
    int guard;
    start = capCount;
    guard = 0;
    while (capCount < start + n && guard < 100 * n) begin
      @(posedge ref_clk);
      guard++;
    end
    // A dead word clock is a failure in its own right.
    if (capCount < start + n) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, capCount - start, n);
    end
    #1;
  endtask

  // Two successive words must be the pair a, b in either phase.
  task automatic pairChk(input logic [11:0] a, input logic [11:0] b);
    logic [11:0] x;
    words(2);
    x = capWord.data;
    words(1);
    chk({15'h0000, (x === a && capWord.data === b) ||
                   (x === b && capWord.data === a)}, 16'h0001);
  endtask

  initial begin
    {rstn, regWr, regRd, synthCoreEnable, adcOverrange} = 5'h00;
    {lanesEnabled, markerPairEnabled, defaultFilters} = 3'h3;
    {regAddr, regWdata, decimRatio, adcData} = {16'h0000, 8'h04, 12'h3a5};
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++)
      rd(regA[i], regR[i]);
    chk({11'h000, loopCap2Select}, 16'h0007);
    chk({12'h000, synthOutActive, lvdsLoadEnable, lvdsDriveCurrent[1:0]},
        16'h0001);
    // Bit 7 is unimplemented; factory bits 6:5 are written, here with their reset value 01.
    wr(8'h5d, 8'hbf);
    rd(8'h5d, 8'h3f);
    chk({11'h000, loopCap2Select}, 16'h001f);
    wr(8'h60, 8'h5a);
    rd(8'h60, 8'h00);
    rd(8'h00, 8'h00);
    @(posedge ref_clk);
    synthCoreEnable <= 1'b1;
    wr(8'h5f, 8'hfd);
    settle();
    chk({15'h0000, synthOutActive}, 16'h0001);
    @(posedge ref_clk);
    synthCoreEnable <= 1'b0;
    repeat (2) settle();
    chk({15'h0000, synthOutActive}, 16'h0000);
    @(posedge ref_clk);
    synthCoreEnable <= 1'b1;
    wr(8'h5f, 8'hf9);
    settle();
    chk({15'h0000, synthOutActive}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr(8'h63, {5'h01, curS[i]});
      settle();
      chk({12'h000, lvdsLoadEnable, lvdsDriveCurrent}, {13'h0001, curS[i]});
    end
    wr(8'h64, 8'h33);
    settle();
    chk({7'h00, clockPhaseDeg}, 16'h0000);
    wr(8'h64, 8'hb3);
    settle();
    chk({7'h00, clockPhaseDeg}, 16'h0087);
    @(posedge ref_clk);
    decimRatio <= 8'h02;
    repeat (2) settle();
    chk({7'h00, clockPhaseDeg}, 16'h0000);
    @(posedge ref_clk);
    {decimRatio, defaultFilters} <= {8'h04, 1'b1};
    wr(8'h64, 8'ha3);
    settle();
    chk({7'h00, clockPhaseDeg}, 16'h0087);
    wr(8'h62, 8'h08);
    words(2);
    chk({4'h0, cmosData}, 16'h03a5);
    wr(8'h62, 8'h28);
    words(2);
    chk({4'h0, cmosData}, 16'h0ba5);
    wr(8'h75, 8'h9c);
    wr(8'h74, 8'h30);
    wr(8'h77, 8'h36);
    wr(8'h76, 8'he0);
    for (int i = 0; i < 5; i++) begin
      wr(8'h62, {5'h01, patS[i]});
      pairChk(patA[i], patB[i]);
    end
    @(posedge ref_clk);
    {lanesEnabled, markerPairEnabled} <= 2'b00;
    words(1);
    chk({2'h0, capWord.data[11:10], dataOen}, {2'h0, capWord.overrange,
        capWord.wordClock, 12'h000});
    chk({10'h000, overrangeOen, wordClockOen, spareOen}, 16'h0000);
    wr(8'h62, 8'h0a);
    words(2);
    r = capWord.data;
    words(8);
    r = capWord.data - r;
    chk({15'h0000, r === 12'h003 || r === 12'h004}, 16'h0001);
    wr(8'h62, 8'h0f);
    words(2);
    r = capWord.data;
    words(1);
    chk({15'h0000, capWord.data !== r}, 16'h0001);
    wr(8'h62, 8'h16);
    words(3);
    chk({4'h0, lvdsWord}, 16'h0ff0);
    chk({10'h000, overrangeOen, wordClockOen, spareOen}, 16'h003f);
    wr(8'h62, 8'h00);
    words(2);
    chk({4'h0, dataOen}, 16'h0fff);
    conclude();
  end

  // Watchdog: the sequence needs well under 10 us.
  initial begin
    #200000;
    mismatches++;
    conclude();
  end
endmodule // test_adc_output_format_config
`default_nettype wire
